// *** inc/fmp_pkg.sv ***
// Constants shared by the flash identify and protection host controller
package fmp_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 8;
   // Unlock and command cycles
   localparam logic [17:0] UNLOCK_ADDR_1 = 18'h0_0555;
   localparam logic [17:0] UNLOCK_ADDR_2 = 18'h0_02AA;
   localparam logic [7:0]  UNLOCK_DATA_1 = 8'hAA;
   localparam logic [7:0]  UNLOCK_DATA_2 = 8'h55;
   localparam logic [7:0]  CMD_IDENTIFY  = 8'h90;
   localparam logic [7:0]  CMD_RESET     = 8'hF0;
   // Identify read offsets
   localparam logic [1:0]  OFS_MAKER     = 2'h0;
   localparam logic [1:0]  OFS_DEVICE    = 2'h1;
   localparam logic [1:0]  OFS_PROTECT   = 2'h2;
   localparam int SECTOR_LSB = 13;
   localparam logic [7:0]  PROT_SET      = 8'h01;
   localparam logic [7:0]  PROT_CLEAR    = 8'h00;
   // Strobe timing
   localparam int CLK_NS       = 4;
   localparam int STROBE_NS    = 40;
   localparam int SETUP_NS     = 20;
   localparam int ACCESS_NS    = 60;
   localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W        = 8;
   typedef enum logic [2:0] {
      FMP_OP_READ, FMP_OP_IDENT_ENTER, FMP_OP_RESET, FMP_OP_HV_IDENT, FMP_OP_WRITE
   } fmp_op_e;
endpackage

// *** design/fmp_host.sv ***
// Host controller driving the flash pins for identify, protect check and reset
`timescale 1ns/1ps
module fmp_host #(
   parameter int ADDR_W = fmp_pkg::ADDR_W
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic               req_valid,
   input  wire fmp_pkg::fmp_op_e   req_op,
   input  wire logic [ADDR_W-1:0]  req_addr,
   input  wire logic [7:0]         req_wdata,
   input  wire logic               timeout_fail_flag,
   output logic                    req_ready,
   output logic                    rsp_valid,
   output logic [7:0]              rsp_rdata,
   output logic                    ident_mode,
   output logic                    fail_seen,
   output logic [ADDR_W-1:0]       flash_addr,
   output logic                    chip_sel_n,
   output logic                    out_en_n,
   output logic                    wr_strobe_n,
   output logic                    id_hv_en,
   output logic [7:0]              data_pins_out,
   output logic                    data_pins_oe,
   input  wire logic [7:0]         data_pins_in
);
   initial begin
      if (ADDR_W != fmp_pkg::ADDR_W) $error("fmp_host: ADDR_W must match pins");
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      FMP_IDLE, FMP_SETUP, FMP_STROBE, FMP_HOLD, FMP_NEXT
   } fmp_state_e;

   fmp_state_e               state_reg;
   logic [fmp_pkg::CNT_W-1:0] cnt_reg;
   logic [1:0]               step_reg;
   logic [1:0]               last_step_reg;
   logic                     is_read_reg;
   fmp_pkg::fmp_op_e         op_reg;
   logic [ADDR_W-1:0]        addr_reg;
   logic [7:0]               wdata_reg;

   localparam logic [fmp_pkg::CNT_W-1:0] SETUP_C  = fmp_pkg::CNT_W'(fmp_pkg::SETUP_CYC);
   localparam logic [fmp_pkg::CNT_W-1:0] STROBE_C = fmp_pkg::CNT_W'(fmp_pkg::STROBE_CYC);
   localparam logic [fmp_pkg::CNT_W-1:0] ACCESS_C = fmp_pkg::CNT_W'(fmp_pkg::ACCESS_CYC);

   // Bus cycle for a given step of an operation: {is_read, addr, data}
   function automatic logic [ADDR_W+8:0] cycle_of(input fmp_pkg::fmp_op_e op,
                                                  input logic [1:0] step,
                                                  input logic [ADDR_W-1:0] a,
                                                  input logic [7:0] d);
      cycle_of = {1'b1, a, 8'h00};
      case (op)
         fmp_pkg::FMP_OP_IDENT_ENTER: begin
            case (step)
               2'd0:    cycle_of = {1'b0, fmp_pkg::UNLOCK_ADDR_1, fmp_pkg::UNLOCK_DATA_1};
               2'd1:    cycle_of = {1'b0, fmp_pkg::UNLOCK_ADDR_2, fmp_pkg::UNLOCK_DATA_2};
               default: cycle_of = {1'b0, fmp_pkg::UNLOCK_ADDR_1, fmp_pkg::CMD_IDENTIFY};
            endcase
         end
         fmp_pkg::FMP_OP_RESET: cycle_of = {1'b0, a, fmp_pkg::CMD_RESET};
         fmp_pkg::FMP_OP_WRITE: cycle_of = {1'b0, a, d};
         default:               cycle_of = {1'b1, a, 8'h00};
      endcase
   endfunction

   logic [ADDR_W+8:0] cyc_now;
   assign cyc_now = cycle_of(op_reg, step_reg, addr_reg, wdata_reg);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= FMP_IDLE;
         cnt_reg       <= '0;
         step_reg      <= 2'd0;
         last_step_reg <= 2'd0;
         op_reg        <= fmp_pkg::FMP_OP_READ;
         addr_reg      <= '0;
         wdata_reg     <= 8'h00;
      end else begin
         case (state_reg)
            FMP_IDLE: begin
               if (req_valid) begin
                  op_reg        <= req_op;
                  addr_reg      <= req_addr;
                  wdata_reg     <= req_wdata;
                  step_reg      <= 2'd0;
                  last_step_reg <= (req_op == fmp_pkg::FMP_OP_IDENT_ENTER) ? 2'd2 : 2'd0;
                  cnt_reg       <= SETUP_C;
                  state_reg     <= FMP_SETUP;
               end
            end
            FMP_SETUP: begin
               cnt_reg <= cnt_reg - 1'b1;
               if (cnt_reg == 1) begin
                  cnt_reg   <= cyc_now[ADDR_W+8] ? ACCESS_C : STROBE_C;
                  state_reg <= FMP_STROBE;
               end
            end
            FMP_STROBE: begin
               // Strobe held well past the glitch filter width
               cnt_reg <= cnt_reg - 1'b1;
               if (cnt_reg == 1) begin
                  cnt_reg   <= SETUP_C;
                  state_reg <= FMP_HOLD;
               end
            end
            FMP_HOLD: begin
               cnt_reg <= cnt_reg - 1'b1;
               if (cnt_reg == 1) state_reg <= FMP_NEXT;
            end
            FMP_NEXT: begin
               if (step_reg == last_step_reg) begin
                  state_reg <= FMP_IDLE;
               end else begin
                  step_reg  <= step_reg + 1'b1;
                  cnt_reg   <= SETUP_C;
                  state_reg <= FMP_SETUP;
               end
            end
            default: state_reg <= FMP_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   logic cyc_read;
   assign cyc_read = cyc_now[ADDR_W+8];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chip_sel_n    <= 1'b1;
         out_en_n      <= 1'b1;
         wr_strobe_n   <= 1'b1;
         flash_addr    <= '0;
         data_pins_out <= 8'h00;
         data_pins_oe  <= 1'b0;
         id_hv_en      <= 1'b0;
         is_read_reg   <= 1'b0;
      end else begin
         is_read_reg <= cyc_read;
         // Address and data stay steady across both strobe edges
         flash_addr    <= cyc_now[ADDR_W+7:8];
         data_pins_out <= cyc_now[7:0];
         // HV identify raises id_hv_en in every non-idle state; addr bit 6 is taken from req_addr, not forced low
         id_hv_en      <= (state_reg != FMP_IDLE) && (op_reg == fmp_pkg::FMP_OP_HV_IDENT);
         chip_sel_n    <= !(state_reg inside {FMP_SETUP, FMP_STROBE, FMP_HOLD});
         data_pins_oe  <= !cyc_read && (state_reg inside {FMP_SETUP, FMP_STROBE, FMP_HOLD});
         // Never overlap output enable with write strobe
         out_en_n      <= !(cyc_read && state_reg == FMP_STROBE);
         wr_strobe_n   <= !(!cyc_read && state_reg == FMP_STROBE);
      end
   end

   // ---------------------------------------------------------------
   // Response and mode tracking
   // ---------------------------------------------------------------
   logic done_pulse;
   assign done_pulse = (state_reg == FMP_NEXT) && (step_reg == last_step_reg);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
         req_ready <= 1'b0;
      end else begin
         req_ready <= (state_reg == FMP_IDLE) && !req_valid;
         rsp_valid <= done_pulse;
         // Sample just before strobe release; identify reads carry codes
         if (state_reg == FMP_STROBE && cnt_reg == 1 && cyc_read)
            rsp_rdata <= data_pins_in;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ident_mode <= 1'b0;
         fail_seen  <= 1'b0;
      end else begin
         if (done_pulse && op_reg == fmp_pkg::FMP_OP_IDENT_ENTER) ident_mode <= 1'b1;
         else if (done_pulse && op_reg == fmp_pkg::FMP_OP_RESET) ident_mode <= 1'b0;
         // Set wins over the reset command clearing it
         if (timeout_fail_flag) fail_seen <= 1'b1;
         else if (done_pulse && op_reg == fmp_pkg::FMP_OP_RESET) fail_seen <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_NO_OE_WE_OVERLAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(!out_en_n && !wr_strobe_n)) else $error("output and write strobes overlap");
   AST_WE_WIDTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(wr_strobe_n) |-> !wr_strobe_n [*2]) else $error("write strobe too short");
   AST_WE_WITH_CS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_strobe_n |-> !chip_sel_n && $stable(flash_addr)) else $error("address moved in write");
   AST_DATA_DRIVEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(wr_strobe_n) |-> data_pins_oe && $stable(data_pins_out))
      else $error("data not held at strobe rise");
   AST_RESET_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_reg == fmp_pkg::FMP_OP_RESET && !wr_strobe_n) |-> data_pins_out == fmp_pkg::CMD_RESET)
      else $error("reset command data wrong");
   AST_IDENT_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (done_pulse && op_reg == fmp_pkg::FMP_OP_RESET) |=> !ident_mode)
      else $error("identify mode not left after reset");
   AST_FAIL_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timeout_fail_flag |=> fail_seen) else $error("fail flag lost");
   AST_HV_ONLY_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
      id_hv_en |-> wr_strobe_n) else $error("write during high-voltage identify");
endmodule

// *** dv/fmp_flash_model.sv ***
// Behavioural flash device answering identify, protect check and reset
`timescale 1ns/1ps
module fmp_flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'hC3, // Arbitrary value
   parameter logic [7:0] DEV_CODE   = 8'h6E  // Arbitrary value
) (
   input  wire logic [17:0] flash_addr,
   input  wire logic        chip_sel_n,
   input  wire logic        out_en_n,
   input  wire logic        wr_strobe_n,
   input  wire logic        id_hv_en,
   input  wire logic [7:0]  data_pins_out,
   input  wire logic        data_pins_oe,
   input  wire logic [31:0] prot_mask,
   output logic      [7:0]  data_pins_in
);
   logic [17:0] addr_reg;
   logic [7:0]  last_reg  = 8'h00;
   logic        ident_reg = 1'b0;
   logic        arm_reg   = 1'b0;
   int          step_reg  = 0;
   logic [7:0]  rd;
   logic [7:0]  d;
   // ----------------------------------------
   // Command cycles
   // ----------------------------------------
   always @(negedge wr_strobe_n or negedge chip_sel_n) begin
      if (!wr_strobe_n && !chip_sel_n) begin
         addr_reg = flash_addr;
         arm_reg  = out_en_n;
      end
   end
   // Armed flag makes only the first rising edge count
   always @(posedge wr_strobe_n or posedge chip_sel_n) begin
      if (arm_reg) begin
         arm_reg = 1'b0;
         d = data_pins_oe ? data_pins_out : ~last_reg;
         // No program or erase engine here: array is read-only, so reset always lands
         if (d == 8'hF0) begin
            ident_reg = 1'b0;
            step_reg  = 0;
         end else if (step_reg == 0 && addr_reg == 18'h0_0555 && d == 8'hAA)
            step_reg = 1;
         else if (step_reg == 1 && addr_reg == 18'h0_02AA && d == 8'h55)
            step_reg = 2;
         else if (step_reg == 2 && addr_reg == 18'h0_0555 && d == 8'h90) begin
            ident_reg = 1'b1;
            step_reg  = 0;
         end else begin
            ident_reg = 1'b0;
            step_reg  = 0;
         end
      end
   end
   always_comb begin
      if ((id_hv_en && !flash_addr[6]) || ident_reg) begin
         case (flash_addr[1:0])
            2'h0:    rd = MAKER_CODE;
            2'h1:    rd = DEV_CODE;
            default: rd = {7'h00, prot_mask[flash_addr[17:13]]};
         endcase
      end else begin
         // Supply always above lockout; no suspend or protect programming modelled
         rd = flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h5A;
      end
   end
   // Released bus shows the inverse so a stale byte never passes
   always @(posedge out_en_n) last_reg = rd;
   assign data_pins_in = (!chip_sel_n && !out_en_n) ? rd : ~last_reg;
endmodule

// *** dv/fmp_host_tb.sv ***
// Self-checking bench for the flash identify and protection host controller
`timescale 1ns/1ps
module fmp_host_tb;
   localparam logic [7:0] MAKER = 8'hC3; // Arbitrary value
   localparam logic [7:0] DEVC  = 8'h6E; // Arbitrary value
   logic             clk_sys, rst_n, req_valid, timeout_fail_flag;
   fmp_pkg::fmp_op_e req_op;
   logic [17:0]      req_addr, flash_addr;
   logic [7:0]       req_wdata, rsp_rdata, data_pins_out, data_pins_in;
   logic             req_ready, rsp_valid, ident_mode, fail_seen, chip_sel_n;
   logic             out_en_n, wr_strobe_n, id_hv_en, data_pins_oe;
   logic [31:0]      prot_mask;
   int               fail_count = 0;
   int               n_tests    = 0;
   fmp_host u_dut (.clk_sys, .rst_n, .req_valid, .req_op, .req_addr, .req_wdata,
      .timeout_fail_flag, .req_ready, .rsp_valid, .rsp_rdata, .ident_mode, .fail_seen,
      .flash_addr, .chip_sel_n, .out_en_n, .wr_strobe_n, .id_hv_en, .data_pins_out,
      .data_pins_oe, .data_pins_in);
   fmp_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVC)) u_flash (.flash_addr, .chip_sel_n,
      .out_en_n, .wr_strobe_n, .id_hv_en, .data_pins_out, .data_pins_oe, .prot_mask,
      .data_pins_in);
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic op(input fmp_pkg::fmp_op_e o, input logic [17:0] ad, input logic [7:0] wd);
      int n;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_op    <= o;
      req_addr  <= ad;
      req_wdata <= wd;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_sys);
         #1;
         if (rsp_valid === 1'b1) break;
      end
      chk({7'h00, n < 100}, 8'h01);
   endtask
   function automatic logic [7:0] exp_rd(input logic [17:0] ad, input bit idm);
      if (!idm) return ad[7:0] ^ ad[15:8] ^ 8'h5A;
      if (ad[1:0] == 2'h0) return MAKER;
      if (ad[1:0] == 2'h1) return DEVC;
      return {7'h00, prot_mask[ad[17:13]]};
   endfunction
   function automatic logic [17:0] id_ad();
      logic [17:0] r;
      r = 18'($urandom);
      r[6] = 1'b0;
      r[1:0] = 2'($urandom_range(2));
      return r;
   endfunction
   task automatic rd_chk(input fmp_pkg::fmp_op_e o, input logic [17:0] ad, input bit idm);
      op(o, ad, 8'h00);
      chk(rsp_rdata, exp_rd(ad, idm));
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // No write strobe while the outputs are enabled
   always @(negedge wr_strobe_n) if (rst_n) chk({7'h00, out_en_n}, 8'h01);
   initial begin
      #80000;
      fail_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_op = fmp_pkg::FMP_OP_READ;
      req_addr = 18'h0_0000;
      req_wdata = 8'h00;
      timeout_fail_flag = 1'b0;
      prot_mask = 32'h0000_0000;
      void'($urandom(32'h5f9e));
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk({7'h00, ident_mode}, 8'h00);
      chk({7'h00, req_ready}, 8'h01);
      for (int i = 0; i < 4; i++) rd_chk(fmp_pkg::FMP_OP_READ, 18'($urandom), 0);
      for (int i = 0; i < 6; i++) rd_chk(fmp_pkg::FMP_OP_HV_IDENT, id_ad(), 1);
      prot_mask = $urandom;
      for (int i = 0; i < 8; i++) rd_chk(fmp_pkg::FMP_OP_HV_IDENT, id_ad(), 1);
      op(fmp_pkg::FMP_OP_IDENT_ENTER, 18'h0_0000, 8'h00);
      chk({7'h00, ident_mode}, 8'h01);
      for (int i = 0; i < 8; i++) rd_chk(fmp_pkg::FMP_OP_READ, id_ad(), 1);
      op(fmp_pkg::FMP_OP_RESET, 18'($urandom), 8'hF0);
      chk({7'h00, ident_mode}, 8'h00);
      for (int i = 0; i < 3; i++) rd_chk(fmp_pkg::FMP_OP_READ, 18'($urandom), 0);
      // Broken unlock: second cycle carries wrong data
      op(fmp_pkg::FMP_OP_WRITE, 18'h0_0555, 8'hAA);
      op(fmp_pkg::FMP_OP_WRITE, 18'h0_02AA, 8'h00);
      op(fmp_pkg::FMP_OP_WRITE, 18'h0_0555, 8'h90);
      for (int i = 0; i < 3; i++) rd_chk(fmp_pkg::FMP_OP_READ, id_ad(), 0);
      @(posedge clk_sys);
      timeout_fail_flag <= 1'b1;
      @(posedge clk_sys);
      timeout_fail_flag <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk({7'h00, fail_seen}, 8'h01);
      op(fmp_pkg::FMP_OP_RESET, 18'($urandom), 8'hF0);
      chk({7'h00, fail_seen}, 8'h00);
      // Mid-run reset with the sticky flag set
      @(posedge clk_sys);
      timeout_fail_flag <= 1'b1;
      @(posedge clk_sys);
      timeout_fail_flag <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk({7'h00, fail_seen}, 8'h00);
      chk({7'h00, req_ready}, 8'h01);
      rd_chk(fmp_pkg::FMP_OP_READ, 18'($urandom), 0);
      tally_and_finish;
   end
endmodule
